// >>> addr_gen_pkg.sv
`default_nettype none
package addr_gen_pkg;

   localparam int ADDR_W = 16;
   localparam int BANK_COUNT = 4;

   // Internal high-speed RAM window used by the stack
   localparam logic [15:0] STACK_RAM_LOW = 16'hFE20;
   localparam logic [15:0] STACK_RAM_HIGH = 16'hFEFF;

   // Values after reset
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] STACK_POINTER_RESET = 16'hFEFF;

   typedef enum logic [3:0] {
      MODE_IDLE = 4'h1,
      MODE_BASED = 4'h2,
      MODE_BASED_INDEXED = 4'h4,
      MODE_STACK = 4'h8
   } addr_mode_e;

   // Request from the instruction decoder
   typedef struct packed {
      logic       valid;
      logic       based;
      logic       based_indexed;
      logic       index_sel_c;
      logic       stack_op;
      logic       interrupt_save;
      logic [7:0] offset;
   } addr_req_s;

   // Contents of one register bank seen by the generator
   typedef struct packed {
      logic [15:0] base_pair;
      logic [7:0]  index_b;
      logic [7:0]  index_c;
   } bank_regs_s;

   typedef bank_regs_s [BANK_COUNT-1:0] bank_array_t;

   // Answer to the memory bus
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic        stack_access;
      logic        stack_range_err;
   } addr_rsp_s;

   function automatic logic [15:0] zext8(input logic [7:0] v);
      zext8 = {8'h00, v};
   endfunction

   function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      add16 = s[15:0];
   endfunction

endpackage

`default_nettype wire

// >>> bank_select.sv
`timescale 1ns/1ps
`default_nettype none

module bank_select (
   // Bank select flags
   input  wire logic                      bank_select_low_in,
   input  wire logic                      bank_select_high_in,
   // All banks
   input  wire addr_gen_pkg::bank_array_t banks_in,
   // Registers of the chosen bank
   output logic [15:0]                    base_pair_out,
   output logic [7:0]                     index_b_out,
   output logic [7:0]                     index_c_out
);
   import addr_gen_pkg::*;

   logic [1:0] bank_idx;

   always_comb begin
      bank_idx      = {bank_select_high_in, bank_select_low_in};
      base_pair_out = banks_in[bank_idx].base_pair;
      index_b_out   = banks_in[bank_idx].index_b;
      index_c_out   = banks_in[bank_idx].index_c;
   end

endmodule

`default_nettype wire

// >>> operand_address_generator.sv
`timescale 1ns/1ps
`default_nettype none

module operand_address_generator (
   // Clock and reset
   input  wire logic                       MCLK_IN,
   input  wire logic                       RESETN_IN,
   // Bank selection and register file view
   input  wire logic                       BANK_SELECT_LOW_IN,
   input  wire logic                       BANK_SELECT_HIGH_IN,
   input  wire addr_gen_pkg::bank_array_t  BANKS_IN,
   input  wire logic [15:0]                STACK_POINTER_IN,
   // Decoder request
   input  wire addr_gen_pkg::addr_req_s    REQ_IN,
   // Memory bus address
   output addr_gen_pkg::addr_rsp_s         RSP_OUT,
   output addr_gen_pkg::addr_mode_e        MODE_OUT
);
   import addr_gen_pkg::*;

   // Register file view of the selected bank
   logic [15:0] sel_base_pair;
   logic [7:0]  sel_index_b;
   logic [7:0]  sel_index_c;

   // Request fields
   logic        req_valid;
   logic        req_stack;
   logic        req_indexed;
   logic        req_based;
   logic        req_use_c;
   logic [7:0]  req_imm;

   // Decoded request
   addr_mode_e  req_mode;
   logic [7:0]  req_index;
   logic [15:0] req_offset;

   // Stack window compare
   logic        below_window;
   logic        above_window;
   logic        req_in_window;

   // Candidate addresses
   logic [15:0] based_sum;
   logic [15:0] indexed_sum;

   // Answer state, one group per field
   logic        valid_reg;
   logic        valid_next;
   logic [15:0] addr_reg;
   logic [15:0] addr_next;
   logic        stack_access_reg;
   logic        stack_access_next;
   logic        range_err_reg;
   logic        range_err_next;
   addr_mode_e  mode_reg;
   addr_mode_e  mode_next;

   // Stack forms win: a push decoded alongside a based form is still a push
   function automatic addr_mode_e decode_mode(input logic valid,
                                              input logic stack,
                                              input logic indexed,
                                              input logic based);
      decode_mode = MODE_IDLE;
      if (valid) begin
         if (stack) begin
            decode_mode = MODE_STACK;
         end else if (indexed) begin
            decode_mode = MODE_BASED_INDEXED;
         end else if (based) begin
            decode_mode = MODE_BASED;
         end
      end
   endfunction

   // Pick between the two index registers named by the instruction
   function automatic logic [7:0] pick_index(input logic       use_c,
                                              input logic [7:0] idx_b,
                                              input logic [7:0] idx_c);
      pick_index = use_c ? idx_c : idx_b;
   endfunction

   bank_select i_bank_select (
      .bank_select_low_in  (BANK_SELECT_LOW_IN),
      .bank_select_high_in (BANK_SELECT_HIGH_IN),
      .banks_in            (BANKS_IN),
      .base_pair_out       (sel_base_pair),
      .index_b_out         (sel_index_b),
      .index_c_out         (sel_index_c)
   );

   // Interrupt saves share the stack path with push, pop, call and return
   always_comb begin
      req_valid   = REQ_IN.valid;
      req_stack   = REQ_IN.stack_op || REQ_IN.interrupt_save;
      req_indexed = REQ_IN.based_indexed;
      req_based   = REQ_IN.based;
      req_use_c   = REQ_IN.index_sel_c;
      req_imm     = REQ_IN.offset;
   end

   // Request decode
   always_comb begin
      req_mode   = decode_mode(req_valid, req_stack, req_indexed, req_based);
      req_index  = pick_index(req_use_c, sel_index_b, sel_index_c);
      req_offset = zext8(req_imm);
   end

   // Stack window, both ends inclusive
   always_comb begin
      below_window  = STACK_POINTER_IN < STACK_RAM_LOW;
      above_window  = STACK_POINTER_IN > STACK_RAM_HIGH;
      req_in_window = !below_window && !above_window;
   end

   // Based path: unsigned offset, carry out of bit 15 dropped
   always_comb begin
      based_sum = add16(sel_base_pair, req_offset);
   end

   // Based indexed path: unsigned index, same wrap, no range limit
   always_comb begin
      indexed_sum = add16(sel_base_pair, zext8(req_index));
   end

   // Answer strobe: one cycle per accepted request
   always_comb begin
      valid_next = (req_mode != MODE_IDLE);
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= valid_next;
      end
   end

   // Effective address; idle cycles show zero, so a stale address never lingers
   always_comb begin
      case (req_mode)
         MODE_STACK: begin
            addr_next = STACK_POINTER_IN;
         end
         MODE_BASED_INDEXED: begin
            addr_next = indexed_sum;
         end
         MODE_BASED: begin
            addr_next = based_sum;
         end
         default: begin
            addr_next = ADDR_RESET;
         end
      endcase
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         addr_reg <= ADDR_RESET;
      end else begin
         addr_reg <= addr_next;
      end
   end

   // Out-of-window stack is flagged, not redirected: the core decides what to do
   always_comb begin
      stack_access_next = 1'b0;
      range_err_next    = 1'b0;
      if (req_mode == MODE_STACK) begin
         stack_access_next = 1'b1;
         range_err_next    = !req_in_window;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         stack_access_reg <= 1'b0;
         range_err_reg    <= 1'b0;
      end else begin
         stack_access_reg <= stack_access_next;
         range_err_reg    <= range_err_next;
      end
   end

   // Mode report
   always_comb begin
      mode_next = req_mode;
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         mode_reg <= MODE_IDLE;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Outputs come straight from the registers above
   always_comb begin
      RSP_OUT.valid           = valid_reg;
      RSP_OUT.addr            = addr_reg;
      RSP_OUT.stack_access    = stack_access_reg;
      RSP_OUT.stack_range_err = range_err_reg;
      MODE_OUT                = mode_reg;
   end

endmodule

`default_nettype wire

// >>> oag_props.sv
`timescale 1ns/1ps
`default_nettype none
module oag_props import addr_gen_pkg::*; (
   input wire logic        MCLK_IN,
   input wire logic        RESETN_IN,
   input wire logic        BANK_SELECT_LOW_IN,
   input wire logic        BANK_SELECT_HIGH_IN,
   input wire bank_array_t BANKS_IN,
   input wire logic [15:0] STACK_POINTER_IN,
   input wire addr_req_s   REQ_IN,
   input wire addr_rsp_s   RSP_OUT,
   input wire addr_mode_e  MODE_OUT
);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RESETN_IN);
   bank_regs_s b;
   logic       st, bi, bs, inw;
   assign b = BANKS_IN[{BANK_SELECT_HIGH_IN, BANK_SELECT_LOW_IN}];
   assign st = REQ_IN.valid && (REQ_IN.stack_op || REQ_IN.interrupt_save);
   assign bi = REQ_IN.valid && !st && REQ_IN.based_indexed;
   assign bs = REQ_IN.valid && !st && !bi && REQ_IN.based;
   assign inw = STACK_POINTER_IN >= STACK_RAM_LOW && STACK_POINTER_IN <= STACK_RAM_HIGH;
   a_based_sum: assert property (bs |=> MODE_OUT == MODE_BASED &&
      RSP_OUT.addr == $past(b.base_pair + {8'h00, REQ_IN.offset})) else $error("based addr");
   a_indexed_sum: assert property (bi |=> MODE_OUT == MODE_BASED_INDEXED &&
      RSP_OUT.addr == $past(b.base_pair + {8'h00, REQ_IN.index_sel_c ? b.index_c : b.index_b}))
      else $error("indexed addr");
   a_stack_addr: assert property (st |=> RSP_OUT.addr == $past(STACK_POINTER_IN)
      && RSP_OUT.stack_access) else $error("stack addr");
   a_stack_mode: assert property (st |=> MODE_OUT == MODE_STACK) else $error("stack mode");
   a_range_flag: assert property (st |=> RSP_OUT.stack_range_err == !$past(inw))
      else $error("range flag");
   a_full_range: assert property ((bs || bi) |=> !RSP_OUT.stack_access
      && !RSP_OUT.stack_range_err) else $error("range limit");
   a_no_wait: assert property ((st || bi || bs) |=> RSP_OUT.valid) else $error("late");
   a_idle_quiet: assert property (!(st || bi || bs) |=> !RSP_OUT.valid
      && MODE_OUT == MODE_IDLE) else $error("spurious");
   cover property (REQ_IN.valid && !(st || bi || bs));
   cover property (bs);
   cover property (bi);
   cover property (st && !inw);
endmodule
bind operand_address_generator oag_props i_oag_props (.*);
`default_nettype wire

// >>> dec_model.sv
`timescale 1ns/1ps
`default_nettype none
module dec_model (
   // Decoded instruction
   input  wire logic                  valid_in,
   input  wire logic [4:0]            kind_in,
   input  wire logic [7:0]            offset_in,
   // Request to the generator
   output var addr_gen_pkg::addr_req_s req_out
);
   import addr_gen_pkg::*;
   // Kind bits: based, indexed, pick C, stack, interrupt save
   assign req_out = {valid_in, kind_in[0], kind_in[1], kind_in[2],
                     kind_in[3], kind_in[4], offset_in};
endmodule
`default_nettype wire

// >>> tb_operand_address_generator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_operand_address_generator;
   import addr_gen_pkg::*;
   logic        clk = 0, rst_n = 0, v = 0, hi = 0, lo = 0;
   logic [4:0]  kind = 0;
   logic [7:0]  offs = 0;
   logic [15:0] sp = 0;
   bank_array_t bk;
   addr_req_s   req;
   addr_rsp_s   rsp;
   addr_mode_e  mode;
   int          failures = 0, n_checks = 0;
   initial forever #12.5 clk = ~clk;
   dec_model i_dec_model (.valid_in(v), .kind_in(kind), .offset_in(offs), .req_out(req));
   operand_address_generator i_operand_address_generator (.MCLK_IN(clk), .RESETN_IN(rst_n),
      .BANK_SELECT_LOW_IN(lo), .BANK_SELECT_HIGH_IN(hi), .BANKS_IN(bk),
      .STACK_POINTER_IN(sp), .REQ_IN(req), .RSP_OUT(rsp), .MODE_OUT(mode));
   task automatic chk(input string n, input logic [15:0] s, e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("BAD %s exp %h saw %h", n, e, s);
      end
   endtask
   // Leaves the request up so calls run back to back
   task automatic op(input logic [4:0] k, input logic [7:0] o, input logic [15:0] ea,
                     input addr_mode_e em);
      kind = k;
      offs = o;
      v = 1;
      @(posedge clk);
      #2;
      chk("valid", rsp.valid, em != MODE_IDLE);
      chk("mode", mode, em);
      if (em != MODE_IDLE) chk("addr", rsp.addr, ea);
      chk("stk", rsp.stack_access, em == MODE_STACK);
   endtask
   task automatic idle;
      v = 0;
      @(posedge clk);
      #2;
      chk("pulse", rsp.valid, 1'h0);
   endtask
   task automatic t_based;
      for (int b = 0; b < 4; b++) begin
         {hi, lo} = 2'(b);
         op(5'h01, 8'h10, bk[b].base_pair + 16'h0010, MODE_BASED);
         op(5'h01, 8'hF0, bk[b].base_pair + 16'h00F0, MODE_BASED);
      end
      idle();
   endtask
   task automatic t_indexed;
      for (int b = 0; b < 4; b++) begin
         {hi, lo} = 2'(b);
         op(5'h02, 8'h00, bk[b].base_pair + {8'h00, bk[b].index_b}, MODE_BASED_INDEXED);
         op(5'h06, 8'h00, bk[b].base_pair + {8'h00, bk[b].index_c}, MODE_BASED_INDEXED);
      end
      idle();
   endtask
   task automatic t_stack;
      logic [15:0] s[4] = '{16'hFE1F, 16'hFE20, 16'hFEFF, 16'hFF00};
      for (int i = 0; i < 4; i++) begin
         sp = s[i];
         op(i[0] ? 5'h10 : 5'h0B, 8'h00, s[i], MODE_STACK);
         chk("range", rsp.stack_range_err, i == 0 || i == 3);
      end
      idle();
   endtask
   task automatic t_refuse;
      op(5'h04, 8'h55, 16'h0000, MODE_IDLE);
      idle();
   endtask
   // Reset in mid-run with a request standing: the request is dropped
   task automatic t_reset;
      {hi, lo} = 2'b00;
      kind = 5'h01;
      offs = 8'h22;
      v = 1;
      rst_n = 0;
      @(posedge clk);
      #2;
      chk("rst valid", rsp.valid, 1'h0);
      chk("rst mode", mode, MODE_IDLE);
      rst_n = 1;
      idle();
      op(5'h01, 8'h22, bk[0].base_pair + 16'h0022, MODE_BASED);
      idle();
   endtask
   task automatic results;
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      // Top bit set on both indices so sign extension would show
      for (int i = 0; i < 4; i++) bk[i] = {~4'(i), 12'hFF8, 4'hF, 4'(i), 4'h8, 4'(i)};
      repeat (6) @(posedge clk);
      #2 rst_n = 1;
      @(posedge clk);
      #2;
      chk("rst", mode, MODE_IDLE);
      chk("rst valid", rsp.valid, 1'h0);
      t_based();
      t_indexed();
      t_reset();
      t_stack();
      t_refuse();
      results();
   end
endmodule
`default_nettype wire
